// ===== core/nmmnu_pkg.sv
package nmmnu_pkg;

  localparam int NIB_W  = 4;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int WIDE_W = 32;

  localparam logic [BYTE_W-1:0] BYTE_MOST_NEG = 8'h80;
  localparam logic [WORD_W-1:0] WORD_MOST_NEG = 16'h8000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO     = 8'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO     = 16'h0000;

  typedef enum logic [1:0] {
    op_nibble_move,
    op_signed_multiply,
    op_unsigned_multiply,
    op_twos_complement_op
  } nmmnu_op_t;

  typedef enum logic [1:0] {
    dir_high_to_high,
    dir_high_to_low,
    dir_low_to_high,
    dir_low_to_low
  } nmmnu_dir_t;

  typedef enum logic {
    size_byte,
    size_word
  } nmmnu_size_t;

  // destination register as named by the decoder
  typedef enum logic [1:0] {
    dst_word_reg_zero,
    dst_word_reg_one,
    dst_addr_reg_zero,
    dst_other
  } nmmnu_dreg_t;

  // where a 32-bit product lands
  typedef enum logic [1:0] {
    pair_none,
    pair_wide_pair_zero,
    pair_wide_pair_one,
    pair_addr_reg_pair
  } nmmnu_pair_t;

  typedef struct packed {
    logic overflow;
    logic sign;
    logic zero;
    logic carry;
  } nmmnu_flags_t;

  typedef struct packed {
    logic              valid;
    nmmnu_op_t         op;
    nmmnu_dir_t        dir;
    nmmnu_size_t       size;
    logic [WORD_W-1:0] src;
    logic [WORD_W-1:0] dst;
    logic              src_addr;
    logic              dst_addr;
    logic              src_r0l;
    logic              dst_r0l;
    nmmnu_dreg_t       dreg;
  } nmmnu_req_t;

  typedef struct packed {
    logic              valid;
    logic              illegal;
    logic              wide;
    nmmnu_pair_t       pair;
    logic [WIDE_W-1:0] data;
    logic              flags_we;
    nmmnu_flags_t      flags;
  } nmmnu_rsp_t;

endpackage : nmmnu_pkg

// ===== core/nmmnu_mult.sv
`timescale 1ns/1ps
// one extra bit per operand lets a single signed multiplier serve both variants
module nmmnu_mult #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]   a_in,
  input  wire logic [W-1:0]   b_in,
  input  wire logic           signed_in,
  output logic      [2*W-1:0] prod_out
);

  logic signed [W:0]     a_x;
  logic signed [W:0]     b_x;
  logic signed [2*W+1:0] p;

  always_comb begin
    a_x      = {signed_in & a_in[W-1], a_in};
    b_x      = {signed_in & b_in[W-1], b_in};
    p        = a_x * b_x;
    prod_out = p[2*W-1:0];
  end

endmodule : nmmnu_mult

// ===== core/nmmnu_unit.sv
`timescale 1ns/1ps
// What this block does
// RULE1 - high-to-high puts the source upper nibble in the destination upper nibble, high-to-low in its lower nibble.
// RULE2 - low-to-high puts the source lower nibble in the destination upper nibble, low-to-low in its lower nibble.
// RULE3 - software names byte register zero-low as source or destination of every nibble move.
// RULE4 - the nibble move keeps the unwritten destination nibble and all flags.
// RULE5 - the signed multiply treats both operands as two's complement and writes their product to the destination.
// RULE6 - byte multiplies take 8-bit operands and store a 16-bit product.
// RULE7 - byte multiplies use only the low 8 bits of an address register operand.
// RULE8 - word multiplies take 16-bit operands and make a 32-bit product.
// RULE9 - a word product for word register zero, one or address register zero lands in its matching pair.
// RULE10 - software never names address registers as both operands of a byte multiply.
// RULE11 - the unsigned multiply treats both operands as plain magnitudes.
// RULE12 - multiplies leave every flag alone.
// RULE13 - negation replaces the destination with zero minus its old value.
// RULE14 - negation sets overflow only when the old value is the most negative of its size.
// RULE15 - negation sets sign from the result msb.
// RULE16 - negation sets zero when the result is zero.
// RULE17 - negation sets carry when the result is zero and clears it otherwise.
module nmmnu_unit
  import nmmnu_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  input  wire nmmnu_req_t   req_in,
  input  wire nmmnu_flags_t flags_in,
  output nmmnu_rsp_t        rsp_out
);

  nmmnu_rsp_t              st_ff;
  nmmnu_rsp_t              nxt_st;
  logic [2*BYTE_W-1:0]     prod_b;
  logic [2*WORD_W-1:0]     prod_w;
  logic                    is_signed;
  logic [BYTE_W-1:0]       neg_b;
  logic [WORD_W-1:0]       neg_w;
  logic [NIB_W-1:0]        nib_pick;

  assign is_signed = (req_in.op == op_signed_multiply); // RULE5

  // byte path only ever sees the low byte, address registers included
  nmmnu_mult #(.W(BYTE_W)) u_mult_byte (
    .a_in      (req_in.dst[BYTE_W-1:0]), // RULE7
    .b_in      (req_in.src[BYTE_W-1:0]),
    .signed_in (is_signed),
    .prod_out  (prod_b)
  );

  nmmnu_mult #(.W(WORD_W)) u_mult_word (
    .a_in      (req_in.dst),
    .b_in      (req_in.src),
    .signed_in (is_signed),
    .prod_out  (prod_w)
  );

  always_comb begin
    neg_b = BYTE_ZERO - req_in.dst[BYTE_W-1:0]; // RULE13
    neg_w = WORD_ZERO - req_in.dst; // RULE13
  end

  always_comb begin
    nxt_st          = '0;
    nxt_st.pair     = pair_none;
    nxt_st.flags    = flags_in; // RULE4 RULE12
    nib_pick        = req_in.src[NIB_W-1:0];
    if (req_in.dir == dir_high_to_high || req_in.dir == dir_high_to_low) begin
      nib_pick = req_in.src[BYTE_W-1:NIB_W];
    end
    if (req_in.valid) begin
      case (req_in.op)
        op_nibble_move: begin
          // an illegal pairing writes nothing rather than guess a target
          if (!(req_in.src_r0l || req_in.dst_r0l)) begin // RULE3
            nxt_st.illegal = 1'b1;
          end else begin
            nxt_st.valid            = 1'b1;
            nxt_st.data[WORD_W-1:0] = req_in.dst; // RULE4
            case (req_in.dir)
              dir_high_to_high: begin
                nxt_st.data[BYTE_W-1:NIB_W] = nib_pick; // RULE1
              end
              dir_high_to_low: begin
                nxt_st.data[NIB_W-1:0] = nib_pick; // RULE1
              end
              dir_low_to_high: begin
                nxt_st.data[BYTE_W-1:NIB_W] = nib_pick; // RULE2
              end
              dir_low_to_low: begin
                nxt_st.data[NIB_W-1:0] = nib_pick; // RULE2
              end
              default: begin
                nxt_st.data[NIB_W-1:0] = nib_pick;
              end
            endcase
          end
        end
        op_signed_multiply, op_unsigned_multiply: begin
          // flags_we stays low for both multiplies
          if (req_in.size == size_byte) begin
            if (req_in.src_addr && req_in.dst_addr) begin // RULE10
              nxt_st.illegal = 1'b1;
            end else begin
              nxt_st.valid                = 1'b1;
              nxt_st.data[2*BYTE_W-1:0]   = prod_b; // RULE5 RULE6 RULE11
            end
          end else begin
            nxt_st.valid = 1'b1;
            nxt_st.wide  = 1'b1;
            nxt_st.data  = prod_w; // RULE8 RULE11
            case (req_in.dreg)
              dst_word_reg_zero: begin
                nxt_st.pair = pair_wide_pair_zero; // RULE9
              end
              dst_word_reg_one: begin
                nxt_st.pair = pair_wide_pair_one; // RULE9
              end
              dst_addr_reg_zero: begin
                nxt_st.pair = pair_addr_reg_pair; // RULE9
              end
              default: begin
                nxt_st.pair = pair_none;
              end
            endcase
          end
        end
        op_twos_complement_op: begin
          nxt_st.valid    = 1'b1;
          nxt_st.flags_we = 1'b1;
          if (req_in.size == size_byte) begin
            // upper byte passes through so a byte write never disturbs it
            nxt_st.data[WORD_W-1:0] = {req_in.dst[WORD_W-1:BYTE_W], neg_b};
            nxt_st.flags.overflow   = (req_in.dst[BYTE_W-1:0] == BYTE_MOST_NEG); // RULE14
            nxt_st.flags.sign       = neg_b[BYTE_W-1]; // RULE15
            nxt_st.flags.zero       = (neg_b == BYTE_ZERO); // RULE16
            nxt_st.flags.carry      = (neg_b == BYTE_ZERO); // RULE17
          end else begin
            nxt_st.data[WORD_W-1:0] = neg_w;
            nxt_st.flags.overflow   = (req_in.dst == WORD_MOST_NEG); // RULE14
            nxt_st.flags.sign       = neg_w[WORD_W-1]; // RULE15
            nxt_st.flags.zero       = (neg_w == WORD_ZERO); // RULE16
            nxt_st.flags.carry      = (neg_w == WORD_ZERO); // RULE17
          end
        end
        default: begin
          nxt_st.illegal = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp_out = st_ff;

  // request decodes shared by the checks below
  logic                    req_nib;
  logic                    req_smul;
  logic                    req_umul;
  logic                    req_neg;

  assign req_nib  = req_in.valid && (req_in.op == op_nibble_move);
  assign req_smul = req_in.valid && (req_in.op == op_signed_multiply);
  assign req_umul = req_in.valid && (req_in.op == op_unsigned_multiply);
  assign req_neg  = req_in.valid && (req_in.op == op_twos_complement_op);

  nib_hh_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE1
    req_in.valid && req_in.op == op_nibble_move && req_in.dir == dir_high_to_high
    && req_in.src_r0l
    |=> rsp_out.valid && rsp_out.data[7:4] == $past(req_in.src[7:4])
        && rsp_out.data[3:0] == $past(req_in.dst[3:0]))
    else $error("nibble high-to-high wrong");

  nib_hl_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE1
    req_in.valid && req_in.op == op_nibble_move && req_in.dir == dir_high_to_low
    && req_in.dst_r0l
    |=> rsp_out.data[3:0] == $past(req_in.src[7:4])
        && rsp_out.data[7:4] == $past(req_in.dst[7:4]))
    else $error("nibble high-to-low wrong");

  nib_lh_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE2
    req_in.valid && req_in.op == op_nibble_move && req_in.dir == dir_low_to_high
    && req_in.src_r0l
    |=> rsp_out.data[7:4] == $past(req_in.src[3:0])
        && rsp_out.data[3:0] == $past(req_in.dst[3:0]))
    else $error("nibble low-to-high wrong");

  nib_ll_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE2
    req_in.valid && req_in.op == op_nibble_move && req_in.dir == dir_low_to_low
    && req_in.dst_r0l
    |=> rsp_out.data[3:0] == $past(req_in.src[3:0])
        && rsp_out.data[15:4] == $past(req_in.dst[15:4]))
    else $error("nibble low-to-low wrong");

  nib_refuse_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE3
    req_nib && !req_in.src_r0l && !req_in.dst_r0l
    |=> rsp_out.illegal && !rsp_out.valid)
    else $error("illegal nibble pairing accepted");

  nib_flags_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE4
    req_nib |=> !rsp_out.flags_we)
    else $error("nibble move touched flags");

  nib_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE4
    req_nib && (req_in.src_r0l || req_in.dst_r0l)
    |=> rsp_out.data[WIDE_W-1:WORD_W] == '0 && rsp_out.flags == $past(flags_in))
    else $error("nibble move disturbed other bits");

  smul_byte_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE5
    req_smul && req_in.size == size_byte && !req_in.src_addr
    |=> rsp_out.valid && !rsp_out.wide && rsp_out.data[15:0] ==
        16'($signed($past(req_in.src[7:0])) * $signed($past(req_in.dst[7:0]))))
    else $error("signed byte product wrong");

  addr_low_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE7
    req_smul && req_in.size == size_byte && req_in.src_addr && !req_in.dst_addr
    |=> rsp_out.valid && rsp_out.data[15:0] ==
        16'($signed($past(req_in.src[7:0])) * $signed($past(req_in.dst[7:0]))))
    else $error("address operand upper byte used");

  smul_word_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE8
    req_smul && req_in.size == size_word
    |=> rsp_out.valid && rsp_out.wide && rsp_out.data ==
        32'($signed($past(req_in.src)) * $signed($past(req_in.dst))))
    else $error("signed word product wrong");

  umul_word_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE11
    req_umul && req_in.size == size_word
    |=> rsp_out.wide && rsp_out.data ==
        32'($past(req_in.src)) * 32'($past(req_in.dst)))
    else $error("unsigned word product wrong");

  umul_byte_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE6
    req_umul && req_in.size == size_byte && !(req_in.src_addr && req_in.dst_addr)
    |=> rsp_out.valid && !rsp_out.wide && rsp_out.data ==
        32'($past(req_in.src[7:0])) * 32'($past(req_in.dst[7:0])))
    else $error("unsigned byte product wrong");

  pair_sel_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE9
    req_in.valid && req_in.op != op_nibble_move && req_in.op != op_twos_complement_op
    && req_in.size == size_word && req_in.dreg == dst_word_reg_one
    |=> rsp_out.pair == pair_wide_pair_one)
    else $error("word product pair wrong");

  pair_zero_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE9
    (req_smul || req_umul) && req_in.size == size_word && req_in.dreg == dst_word_reg_zero
    |=> rsp_out.pair == pair_wide_pair_zero)
    else $error("word product pair zero wrong");

  pair_addr_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE9
    (req_smul || req_umul) && req_in.size == size_word && req_in.dreg == dst_addr_reg_zero
    |=> rsp_out.pair == pair_addr_reg_pair)
    else $error("word product address pair wrong");

  mul_refuse_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE10
    (req_smul || req_umul) && req_in.size == size_byte
    && req_in.src_addr && req_in.dst_addr
    |=> rsp_out.illegal && !rsp_out.valid ##1 (!rsp_out.illegal || $past(req_in.valid)))
    else $error("address pair byte multiply accepted");

  mul_flags_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE12
    req_smul || req_umul |=> !rsp_out.flags_we)
    else $error("multiply touched flags");

  mul_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE12
    req_smul || req_umul |=> rsp_out.flags == $past(flags_in))
    else $error("multiply changed flag value");

  neg_ovf_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE14
    req_neg && req_in.size == size_word
    |=> rsp_out.flags_we && rsp_out.flags.overflow == ($past(req_in.dst) == WORD_MOST_NEG))
    else $error("negate overflow wrong");

  neg_word_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE13
    req_neg && req_in.size == size_word
    |=> rsp_out.valid && rsp_out.flags_we && !rsp_out.wide
        && rsp_out.data == 32'(16'(~$past(req_in.dst) + 16'h0001))
        && rsp_out.flags.sign == rsp_out.data[15] // RULE15
        && rsp_out.flags.zero == ($past(req_in.dst) == WORD_ZERO) // RULE16
        && rsp_out.flags.carry == rsp_out.flags.zero) // RULE17
    else $error("negate word result or flags wrong");

  neg_flags_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE16
    req_neg && req_in.size == size_byte
    |=> rsp_out.flags.zero == ($past(req_in.dst[7:0]) == 8'h00)
        && rsp_out.flags.carry == rsp_out.flags.zero // RULE17
        && rsp_out.flags.sign == rsp_out.data[7] // RULE15
        && rsp_out.data[7:0] == 8'(~$past(req_in.dst[7:0]) + 8'h01)) // RULE13
    else $error("negate byte result or flags wrong");

  neg_byte_ovf_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RULE14
    req_neg && req_in.size == size_byte
    |=> rsp_out.flags.overflow == ($past(req_in.dst[7:0]) == BYTE_MOST_NEG)
        && rsp_out.data[15:8] == $past(req_in.dst[15:8])
        && rsp_out.data[31:16] == '0)
    else $error("negate byte overflow or upper byte wrong");

  idle_quiet_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !req_in.valid |=> !rsp_out.valid && !rsp_out.illegal && !rsp_out.flags_we)
    else $error("response without request");

  neg_min_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    req_neg && req_in.dst == WORD_MOST_NEG);
  neg_zero_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    req_neg ##1 rsp_out.flags.zero);
  wide_pair_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    rsp_out.wide && rsp_out.pair == pair_addr_reg_pair);
  nib_back_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    req_nib ##1 req_smul);
  mul_refuse_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
    req_umul && req_in.src_addr && req_in.dst_addr ##1 rsp_out.illegal);

endmodule : nmmnu_unit

// ===== sim/nmmnu_unit_tb.sv
`timescale 1ns/1ps
module nmmnu_unit_tb
  import nmmnu_pkg::*;
;
  typedef struct packed {
    nmmnu_req_t   req;
    nmmnu_flags_t fin;
    nmmnu_rsp_t   exp;
  } nmmnu_row_t;

  logic         clock_in;
  logic         rstn_in;
  nmmnu_req_t   req_in;
  nmmnu_flags_t flags_in;
  nmmnu_rsp_t   rsp_out;
  int           errors;
  int           compares;
  nmmnu_row_t   rows[$];

  nmmnu_unit u_dut (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .req_in   (req_in),
    .flags_in (flags_in),
    .rsp_out  (rsp_out)
  );

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // at = {src_addr, dst_addr, src_r0l, dst_r0l}
  function automatic nmmnu_row_t base(nmmnu_op_t op, nmmnu_size_t sz, logic [15:0] s,
                                      logic [15:0] d, logic [3:0] at, logic [3:0] fin);
    nmmnu_row_t r;
    r = '0;
    r.req.valid = 1'b1;
    r.req.op = op;
    r.req.size = sz;
    r.req.src = s;
    r.req.dst = d;
    {r.req.src_addr, r.req.dst_addr, r.req.src_r0l, r.req.dst_r0l} = at;
    r.req.dreg = dst_other;
    r.fin = fin;
    r.exp.valid = 1'b1;
    r.exp.flags = fin;
    return r;
  endfunction : base

  function automatic nmmnu_row_t nib(nmmnu_dir_t dir, logic [15:0] s, logic [15:0] d,
                                     logic [3:0] at, logic [31:0] data);
    nmmnu_row_t r;
    r = base(op_nibble_move, size_byte, s, d, at, 4'hA);
    r.req.dir = dir;
    r.exp.data = data;
    return r;
  endfunction : nib

  function automatic nmmnu_row_t mul(nmmnu_op_t op, nmmnu_size_t sz, logic [15:0] s,
                                     logic [15:0] d, logic [3:0] at, nmmnu_dreg_t dreg,
                                     nmmnu_pair_t pair, logic [31:0] data);
    nmmnu_row_t r;
    r = base(op, sz, s, d, at, 4'h5);
    r.req.dreg = dreg;
    r.exp.wide = (sz == size_word);
    r.exp.pair = pair;
    r.exp.data = data;
    return r;
  endfunction : mul

  // incoming flags are the inverse of the expected ones so every flag must move
  function automatic nmmnu_row_t neg(nmmnu_size_t sz, logic [15:0] d, logic [31:0] data,
                                     logic [3:0] fl);
    nmmnu_row_t r;
    r = base(op_twos_complement_op, sz, 16'hFFFF, d, 4'h0, ~fl);
    r.exp.flags_we = 1'b1;
    r.exp.flags = fl;
    r.exp.data = data;
    return r;
  endfunction : neg

  function automatic nmmnu_row_t bad(nmmnu_op_t op, logic [3:0] at);
    nmmnu_row_t r;
    r = base(op, size_byte, 16'h0011, 16'h0022, at, 4'h9);
    r.exp.valid = 1'b0;
    r.exp.illegal = 1'b1;
    return r;
  endfunction : bad

  // data, width and pair only matter when a write-back is announced
  task automatic chk(input nmmnu_rsp_t exp);
    compares++;
    if (rsp_out.valid !== exp.valid || rsp_out.illegal !== exp.illegal ||
        rsp_out.flags_we !== exp.flags_we || rsp_out.flags !== exp.flags ||
        (exp.valid && (rsp_out.wide !== exp.wide || rsp_out.pair !== exp.pair ||
                       rsp_out.data !== exp.data))) begin
      errors++;
      $display("MISMATCH %0t response got %h exp %h", $time, rsp_out, exp);
    end
  endtask : chk

  task automatic chk_all(input nmmnu_rsp_t exp);
    compares++;
    if (rsp_out !== exp) begin
      errors++;
      $display("MISMATCH %0t whole response got %h exp %h", $time, rsp_out, exp);
    end
  endtask : chk_all

  task automatic print_verdict;
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (2000) @(posedge clock_in);
    errors++;
    print_verdict();
  end

  initial begin : main
    nmmnu_row_t r;
    nmmnu_rsp_t idle;
    rstn_in = 1'b0;
    req_in = '0;
    flags_in = '0;
    rows = '{
      nib(dir_high_to_high, 16'h00A5, 16'h123C, 4'h2, 32'h000012AC),
      nib(dir_high_to_low, 16'h00A5, 16'h123C, 4'h1, 32'h0000123A),
      nib(dir_low_to_high, 16'h00A5, 16'h123C, 4'h2, 32'h0000125C),
      nib(dir_low_to_low, 16'h00A5, 16'h123C, 4'h1, 32'h00001235),
      bad(op_nibble_move, 4'hC),
      mul(op_signed_multiply, size_byte, 16'h00FE, 16'h0003, 4'h0, dst_other,
          pair_none, 32'h0000FFFA),
      mul(op_unsigned_multiply, size_byte, 16'h00FE, 16'h0003, 4'h0, dst_other,
          pair_none, 32'h000002FA),
      mul(op_signed_multiply, size_byte, 16'h7F81, 16'h0002, 4'h8, dst_other,
          pair_none, 32'h0000FF02),
      mul(op_unsigned_multiply, size_byte, 16'h0010, 16'hAB10, 4'h4, dst_other,
          pair_none, 32'h00000100),
      bad(op_signed_multiply, 4'hC),
      bad(op_unsigned_multiply, 4'hC),
      mul(op_signed_multiply, size_word, 16'hFFFF, 16'h8000, 4'h0, dst_word_reg_zero,
          pair_wide_pair_zero, 32'h00008000),
      mul(op_unsigned_multiply, size_word, 16'hFFFF, 16'hFFFF, 4'h0, dst_word_reg_one,
          pair_wide_pair_one, 32'hFFFE0001),
      mul(op_signed_multiply, size_word, 16'h0100, 16'hFF00, 4'h4, dst_addr_reg_zero,
          pair_addr_reg_pair, 32'hFFFF0000),
      mul(op_signed_multiply, size_word, 16'h0003, 16'h0005, 4'h0, dst_other,
          pair_none, 32'h0000000F),
      neg(size_byte, 16'h7780, 32'h00007780, 4'hC),
      neg(size_byte, 16'h5500, 32'h00005500, 4'h3),
      neg(size_byte, 16'h0001, 32'h000000FF, 4'h4),
      neg(size_word, 16'h8000, 32'h00008000, 4'hC),
      neg(size_word, 16'h0000, 32'h00000000, 4'h3),
      neg(size_word, 16'h7FFF, 32'h00008001, 4'h4)
    };
    repeat (5) @(negedge clock_in);
    chk_all('0);
    rstn_in = 1'b1;
    // each row is issued one edge after the last, so results are checked back to back
    for (int i = 0; i <= rows.size(); i++) begin
      @(negedge clock_in);
      if (i > 0) begin
        chk(rows[i-1].exp);
      end
      if (i < rows.size()) begin
        req_in = rows[i].req;
        flags_in = rows[i].fin;
      end else begin
        req_in = '0;
        flags_in = 4'h6;
      end
    end
    idle = '0;
    idle.flags = 4'h6;
    @(negedge clock_in);
    chk_all(idle);
    // reset in mid-run must clear a pending result without a clock edge
    r = neg(size_byte, 16'h0002, 32'h000000FE, 4'h4);
    req_in = r.req;
    flags_in = r.fin;
    @(negedge clock_in);
    chk(r.exp);
    rstn_in = 1'b0;
    #1;
    chk_all('0);
    @(negedge clock_in);
    rstn_in = 1'b1;
    @(negedge clock_in);
    chk(r.exp);
    req_in = '0;
    print_verdict();
  end
endmodule : nmmnu_unit_tb
